// file: rtl/ufsa_core.sv
// User flash block: serial/array access, busy, stream read, oscillator, Avalon slave
// How it works
// R1: The reference clock divided by eight leaves the block as a clock output.
// R2: The exported clock has a fixed rate with no software setting.
// R3: Program, erase and read steps are timed by the internal oscillator ticks.
// R4: A program or erase request starts a self-running internal algorithm.
// R5: The requester keeps program or erase high until busy falls.
// R6: Busy stays high through a program or erase and falls only when it ends.
// R7: Both single reads and streamed consecutive reads are supported.
// R8: With shift select low, each address shift clock pulse adds one to the address.
// R9: Address and data move through 9-bit and 16-bit serial shift registers.
// R10: A test access port path can also program and read the block; here the test port only shifts the write word in and the read word out.
// R11: The address shift clock may be driven from any of four global clock lines or from routing.
// R12: With shift select high, each address shift clock pulse shifts in one address bit.
// R13: The store is 512 words of 16 bits, addressed by all 9 address bits.
`include "ufsa_defines.svh"
`default_nettype none
module ufsa_core #(
   parameter int ADDR_W = `UFSA_ADDR_W,
   parameter int DATA_W = `UFSA_DATA_W,
   parameter int WORDS = `UFSA_WORDS,
   parameter int FIFO_DEPTH = `UFSA_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic program_req,
   input wire logic erase_req,
   input wire logic addr_shift_select,
   input wire logic addr_shift_clock,
   input wire logic addr_serial_in,
   input wire logic data_shift_clock,
   input wire logic data_serial_in,
   output logic data_serial_out,
   input wire logic [3:0] global_clock_lines,
   input wire logic jtag_shift,
   input wire logic jtag_tdi,
   output logic jtag_tdo,
   output logic busy,
   output logic internal_osc_out
);
   localparam int FAW = $clog2(FIFO_DEPTH);

   // ****************************************
   // Oscillator and divide-by-eight clock
   // ****************************************
   logic [1:0] osc_cnt_reg, osc_cnt_next;
   logic osc_out_reg, osc_out_next;
   logic osc_tick;

   always_comb begin
      osc_cnt_next = osc_cnt_reg + 2'h1;
      osc_tick = (osc_cnt_reg == 2'(`UFSA_OSC_HALF));
      osc_out_next = osc_tick ? ~osc_out_reg : osc_out_reg; // [R1] [R2]
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         osc_cnt_reg <= 2'h0;
         osc_out_reg <= 1'b0;
      end else begin
         osc_cnt_reg <= osc_cnt_next;
         osc_out_reg <= osc_out_next;
      end
   end

   // ****************************************
   // Input selection and edge detect
   // ****************************************
   logic [31:0] ctrl_reg, ctrl_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic aclk_q_reg, dclk_q_reg;
   logic prog_in, aclk_in, gsel;
   logic aclk_rise, dclk_rise;

   always_comb begin
      gsel = ctrl_reg[`UFSA_CTRL_GCLK_SEL];
      aclk_in = gsel ? global_clock_lines[ctrl_reg[`UFSA_CTRL_GCLK_IDX +: 2]] // [R11]
                     : addr_shift_clock;
      prog_in = program_req | ctrl_reg[`UFSA_CTRL_PROGRAM];
      aclk_rise = aclk_in && !aclk_q_reg;
      dclk_rise = data_shift_clock && !dclk_q_reg;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         aclk_q_reg <= 1'b0;
         dclk_q_reg <= 1'b0;
      end else begin
         aclk_q_reg <= aclk_in;
         dclk_q_reg <= data_shift_clock;
      end
   end

   // ****************************************
   // Flash array and operation engine
   // ****************************************
   logic [DATA_W-1:0] flash_mem [WORDS];
   ufsa_pkg::ufsa_state_t state_reg, state_next;
   logic [6:0] tick_reg, tick_next;
   logic busy_reg, busy_next;
   logic do_prog, do_erase, erase_req_any, read_req_any, push;
   logic fifo_ready;
   logic [FAW:0] fifo_level;
   logic fifo_valid;
   logic [DATA_W-1:0] fifo_data;

   always_comb begin
      erase_req_any = erase_req | ctrl_reg[`UFSA_CTRL_ERASE];
      read_req_any = ctrl_reg[`UFSA_CTRL_READ];
      state_next = state_reg;
      tick_next = tick_reg;
      busy_next = busy_reg;
      do_prog = 1'b0;
      do_erase = 1'b0;
      push = 1'b0;
      case (state_reg)
         ufsa_pkg::UFSA_IDLE: begin
            tick_next = 7'h0;
            if (prog_in) begin
               state_next = ufsa_pkg::UFSA_PROG; // [R4]
               busy_next = 1'b1;
            end else if (erase_req_any) begin
               state_next = ufsa_pkg::UFSA_ERASE; // [R4]
               busy_next = 1'b1;
            end else if (read_req_any && fifo_ready) begin
               state_next = ufsa_pkg::UFSA_READ; // [R7]
               busy_next = 1'b1;
            end
         end
         ufsa_pkg::UFSA_PROG: begin
            if (osc_tick) begin
               tick_next = tick_reg + 7'h1; // [R3]
            end
            if (tick_reg == 7'(`UFSA_PROG_OSC_TICKS)) begin
               do_prog = 1'b1;
               state_next = ufsa_pkg::UFSA_DONE;
            end
         end
         ufsa_pkg::UFSA_ERASE: begin
            if (osc_tick) begin
               tick_next = tick_reg + 7'h1; // [R3]
            end
            if (tick_reg == 7'(`UFSA_ERASE_OSC_TICKS)) begin
               do_erase = 1'b1;
               state_next = ufsa_pkg::UFSA_DONE;
            end
         end
         ufsa_pkg::UFSA_READ: begin
            if (osc_tick) begin
               tick_next = tick_reg + 7'h1; // [R3]
            end
            if (tick_reg == 7'(`UFSA_READ_OSC_TICKS)) begin
               push = 1'b1;
               state_next = ufsa_pkg::UFSA_DONE;
            end
         end
         ufsa_pkg::UFSA_DONE: begin
            busy_next = 1'b0; // [R6]
            // Hold here until the requester lets go, so one request is one operation
            if (!prog_in && !erase_req_any) begin // [R5]
               state_next = ufsa_pkg::UFSA_IDLE;
            end
         end
         default: begin
            state_next = ufsa_pkg::UFSA_IDLE;
            busy_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ufsa_pkg::UFSA_IDLE;
         tick_reg <= 7'h0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tick_reg <= tick_next;
         busy_reg <= busy_next;
      end
      if (do_prog) begin
         flash_mem[addr_reg] <= flash_mem[addr_reg] & wdata_reg; // [R13]
      end
      if (do_erase) begin
         for (int i = 0; i < WORDS; i++) begin
            flash_mem[i] <= '1;
         end
      end
   end

   // ****************************************
   // Address, data and test-port shift registers
   // ****************************************
   logic jtag_tdo_reg, jtag_tdo_next;
   logic bus_wr, bus_rd, bus_done_reg, bus_done_next;
   logic wait_reg, wait_next;
   logic [31:0] rd_mux_reg, rd_mux_next;
   logic stream_adv, read_cmd_clr;

   always_comb begin
      bus_wr = avs_write && !bus_done_reg;
      bus_rd = avs_read && !bus_done_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      jtag_tdo_next = jtag_tdo_reg;
      stream_adv = push && ctrl_reg[`UFSA_CTRL_STREAM];
      read_cmd_clr = push && !ctrl_reg[`UFSA_CTRL_STREAM];
      if (aclk_rise) begin
         if (addr_shift_select) begin
            addr_next = {addr_reg[ADDR_W-2:0], addr_serial_in}; // [R12] [R9]
         end else begin
            addr_next = addr_reg + ADDR_W'(1); // [R8]
         end
      end else if (stream_adv) begin
         addr_next = addr_reg + ADDR_W'(1); // [R7] [R13]
      end
      if (push) begin
         rdata_next = flash_mem[addr_reg];
      end
      if (dclk_rise) begin
         // Data leaves MSB first while new data enters the bottom
         wdata_next = {wdata_reg[DATA_W-2:0], data_serial_in}; // [R9]
         rdata_next = {rdata_reg[DATA_W-2:0], 1'b0};
      end
      if (jtag_shift) begin
         // Test port shifts the same data registers: write word in, read word out
         wdata_next = {wdata_reg[DATA_W-2:0], jtag_tdi}; // [R10]
         rdata_next = {rdata_reg[DATA_W-2:0], 1'b0};
         jtag_tdo_next = rdata_reg[DATA_W-1];
      end
      if (read_cmd_clr) begin
         ctrl_next[`UFSA_CTRL_READ] = 1'b0;
      end
      if (bus_wr) begin
         case (avs_address)
            `UFSA_REG_CTRL: ctrl_next = avs_writedata;
            `UFSA_REG_ADDR: addr_next = avs_writedata[ADDR_W-1:0];
            `UFSA_REG_WDATA: wdata_next = avs_writedata[DATA_W-1:0];
            default: begin
            end
         endcase
      end
      case (avs_address)
         `UFSA_REG_CTRL: rd_mux_next = ctrl_reg;
         `UFSA_REG_STATUS: rd_mux_next = {30'h0, fifo_valid, busy_reg};
         `UFSA_REG_ADDR: rd_mux_next = {{(32-ADDR_W){1'b0}}, addr_reg};
         `UFSA_REG_WDATA: rd_mux_next = {{(32-DATA_W){1'b0}}, wdata_reg};
         `UFSA_REG_RDATA: rd_mux_next = {{(32-DATA_W){1'b0}}, fifo_data};
         `UFSA_REG_LEVEL: rd_mux_next = {{(31-FAW){1'b0}}, fifo_level};
         default: rd_mux_next = 32'h0;
      endcase
      bus_done_next = (avs_read || avs_write) && !bus_done_reg;
      wait_next = !bus_done_next;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_reg <= '0;
         wdata_reg <= '1;
         rdata_reg <= '0;
         ctrl_reg <= 32'h0;
         jtag_tdo_reg <= 1'b0;
         rd_mux_reg <= 32'h0;
         bus_done_reg <= 1'b0;
         wait_reg <= 1'b1;
      end else begin
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         jtag_tdo_reg <= jtag_tdo_next;
         rd_mux_reg <= bus_rd ? rd_mux_next : rd_mux_reg;
         bus_done_reg <= bus_done_next;
         wait_reg <= wait_next;
      end
   end

   // ****************************************
   // Read data FIFO
   // ****************************************
   ufsa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(flash_mem[addr_reg]),
      .out_valid(fifo_valid),
      .out_ready(bus_rd && avs_address == `UFSA_REG_RDATA),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   assign avs_readdata = rd_mux_reg;
   assign avs_waitrequest = wait_reg;
   assign data_serial_out = rdata_reg[DATA_W-1];
   assign jtag_tdo = jtag_tdo_reg;
   assign busy = busy_reg;
   assign internal_osc_out = osc_out_reg;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_prog_start;
      state_reg == ufsa_pkg::UFSA_IDLE && prog_in;
   endsequence

   a_busy_rises: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
      s_prog_start |=> busy)
      else $error("busy did not rise on program");
   a_busy_holds_prog: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
      s_prog_start |=> busy [*8])
      else $error("busy fell early during program");
   a_osc_period: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
      $rose(internal_osc_out) |-> ##1 internal_osc_out ##3 !internal_osc_out)
      else $error("oscillator output period wrong");
   a_addr_incr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
      aclk_rise && !addr_shift_select && !bus_wr |=> addr_reg == $past(addr_reg) + ADDR_W'(1))
      else $error("address did not advance");
   a_addr_shift: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
      aclk_rise && addr_shift_select && !bus_wr
      |=> addr_reg[0] == $past(addr_serial_in))
      else $error("address bit not shifted in");
   a_read_done: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
      $rose(state_reg == ufsa_pkg::UFSA_READ) |-> ##[1:16] push)
      else $error("read did not finish in time");
   a_busy_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
      state_reg == ufsa_pkg::UFSA_DONE |=> !busy)
      else $error("busy stuck after operation");
   a_data_shift: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
      dclk_rise && !jtag_shift && !bus_wr |=> wdata_reg[0] == $past(data_serial_in))
      else $error("data bit not shifted in");
endmodule : ufsa_core
`default_nettype wire

// file: rtl/ufsa_defines.svh
// Constants for the user flash serial access block
`ifndef UFSA_DEFINES_SVH
`define UFSA_DEFINES_SVH

// ****************************************
// Geometry
// ****************************************
`define UFSA_ADDR_W 9
`define UFSA_DATA_W 16
`define UFSA_WORDS 512
`define UFSA_FIFO_DEPTH 32

// ****************************************
// Clocking and operation timing
// ****************************************
`define UFSA_REF_CLK_HZ 25000000
`define UFSA_OSC_DIV 4
`define UFSA_OSC_HALF 3
`define UFSA_PROG_OSC_TICKS 16
`define UFSA_ERASE_OSC_TICKS 64
`define UFSA_READ_OSC_TICKS 2

// ****************************************
// Register map, byte addresses
// ****************************************
`define UFSA_REG_CTRL 8'h00
`define UFSA_REG_STATUS 8'h04
`define UFSA_REG_ADDR 8'h08
`define UFSA_REG_WDATA 8'h0c
`define UFSA_REG_RDATA 8'h10
`define UFSA_REG_LEVEL 8'h14

// CTRL bit positions
`define UFSA_CTRL_PROGRAM 0
`define UFSA_CTRL_ERASE 1
`define UFSA_CTRL_READ 2
`define UFSA_CTRL_STREAM 3
`define UFSA_CTRL_JTAG_SEL 4
`define UFSA_CTRL_GCLK_SEL 5
`define UFSA_CTRL_GCLK_IDX 6

`endif

// file: rtl/ufsa_fifo.sv
// Parameterised valid/ready FIFO for read data
`default_nettype none
module ufsa_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rp_reg];
   assign level = cnt_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wp_next = push ? wp_reg + AW'(1) : wp_reg;
      rp_next = pop ? rp_reg + AW'(1) : rp_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end
endmodule : ufsa_fifo
`default_nettype wire

// file: rtl/ufsa_pkg.sv
// Types shared by the user flash serial access block
`default_nettype none
package ufsa_pkg;
   typedef enum logic [4:0] {
      UFSA_IDLE = 5'h01,
      UFSA_PROG = 5'h02,
      UFSA_ERASE = 5'h04,
      UFSA_READ = 5'h08,
      UFSA_DONE = 5'h10
   } ufsa_state_t;
endpackage : ufsa_pkg
`default_nettype wire

// file: tb/ufsa_core_tb.sv
// Self-checking testbench of the user flash serial access block
`include "ufsa_defines.svh"
`default_nettype none
module ufsa_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic program_req, erase_req, addr_shift_select, addr_shift_clock, addr_serial_in;
   logic data_shift_clock = 1'b0;
   logic data_serial_in = 1'b0;
   logic [3:0] global_clock_lines = 4'h0;
   logic jtag_shift = 1'b0;
   logic jtag_tdi = 1'b0;
   logic data_serial_out, jtag_tdo, busy, internal_osc_out;
   int errors = 0;
   int comparisons = 0;
   int mem [512];
   logic [31:0] seed = 32'h2a;
   logic [31:0] v, d;
   logic [3:0] gl = 4'h0;
   logic [8:0] s;
   int c, n;
   always #20 ref_clk = ~ref_clk;
   ufsa_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .program_req(program_req), .erase_req(erase_req),
      .addr_shift_select(addr_shift_select), .addr_shift_clock(addr_shift_clock),
      .addr_serial_in(addr_serial_in), .data_shift_clock(data_shift_clock),
      .data_serial_in(data_serial_in), .data_serial_out(data_serial_out),
      .global_clock_lines(global_clock_lines), .jtag_shift(jtag_shift),
      .jtag_tdi(jtag_tdi), .jtag_tdo(jtag_tdo), .busy(busy),
      .internal_osc_out(internal_osc_out));
   ufsa_user_logic i_usr (.ref_clk(ref_clk), .busy(busy), .program_req(program_req),
      .erase_req(erase_req), .addr_shift_select(addr_shift_select),
      .addr_shift_clock(addr_shift_clock), .addr_serial_in(addr_serial_in));
   // ****************************************
   // Helpers
   // ****************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   always @(posedge ref_clk) begin
      global_clock_lines <= gl;
      jtag_tdi <= seed[4];
      data_serial_in <= seed[5];
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      k = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++k < 100);
      rd = avs_readdata;
      if (k >= 100) check("bus answer", 32'h1, 32'h0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic single_read(input logic [8:0] a, output logic [31:0] rd);
      int k;
      k = 0;
      bus(1, `UFSA_REG_ADDR, {23'h0, a}, rd);
      bus(1, `UFSA_REG_CTRL, 32'h4, rd);
      do bus(0, `UFSA_REG_STATUS, 0, rd); while (rd[1] !== 1'b1 && ++k < 50);
      bus(0, `UFSA_REG_RDATA, 0, rd);
   endtask : single_read
   task automatic program_word(input logic [8:0] a);
      v = {16'h0, 16'(rnd())};
      bus(1, `UFSA_REG_ADDR, {23'h0, a}, d);
      bus(1, `UFSA_REG_WDATA, v, d);
      mem[a] &= v[15:0];
      i_usr.flash_op(0, rnd() % 3, c);
      n = `UFSA_OSC_DIV * `UFSA_PROG_OSC_TICKS;
      check("program busy span", c >= n - 1 && c <= n + `UFSA_OSC_DIV, 1);
   endtask : program_word
   task automatic osc_period();
      realtime t0;
      @(posedge internal_osc_out);
      t0 = $realtime;
      @(posedge internal_osc_out);
      check("osc period", ($realtime - t0) / 40.0, 2 * `UFSA_OSC_DIV);
   endtask : osc_period
   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #(40 * 60000);
      errors++;
      end_of_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      check("busy idle", busy, 0);
      check("wait idle", avs_waitrequest, 1);
      bus(0, `UFSA_REG_LEVEL, 0, v);
      check("level reset", v, 0);
      osc_period();
      i_usr.flash_op(1, 2, c);
      n = `UFSA_OSC_DIV * `UFSA_ERASE_OSC_TICKS;
      check("erase busy span", c >= n - 1 && c <= n + `UFSA_OSC_DIV, 1);
      for (int i = 0; i < 512; i++) mem[i] = 'hffff;
      s = 9'h1f8;
      program_word(s);
      program_word(s);
      program_word(s + 9'h1);
      program_word(9'h1ff);
      program_word(9'h0);
      single_read(9'h1ff, v);
      check("single read", v, mem[511]);
      bus(0, `UFSA_REG_CTRL, 0, v);
      check("read bit clears", v[2], 0);
      d = mem[511];
      @(posedge ref_clk);
      jtag_shift <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(posedge ref_clk);
         if (i == 7) jtag_shift <= 1'b0;
         if (i > 0) check("tap read bit", jtag_tdo, d[16 - i]);
      end
      for (int i = 0; i < 8; i++) begin
         check("serial read bit", data_serial_out, d[7 - i]);
         @(posedge ref_clk) data_shift_clock <= 1'b1;
         @(posedge ref_clk) data_shift_clock <= 1'b0;
         @(posedge ref_clk);
      end
      bus(0, `UFSA_REG_WDATA, 0, v);
      check("shifted in data", v, {16'h0, {8{seed[4]}}, {8{seed[5]}}});
      i_usr.shift_addr(s + 9'h1, 2 + rnd() % 3);
      bus(0, `UFSA_REG_ADDR, 0, v);
      check("shifted addr", v, {23'h0, s + 9'h1});
      i_usr.shift_addr(9'h1ff, 2);
      i_usr.inc_addr(1, 2 + rnd() % 3);
      bus(0, `UFSA_REG_ADDR, 0, v);
      check("addr wrap", v, 0);
      i_usr.inc_addr(3, 2);
      bus(0, `UFSA_REG_ADDR, 0, v);
      check("addr inc", v, 3);
      n = rnd() % 4;
      bus(1, `UFSA_REG_CTRL, 32'h20 | (n << 6), d);
      repeat (3) begin
         @(posedge ref_clk) gl[n] <= 1'b1;
         @(posedge ref_clk) gl[n] <= 1'b0;
      end
      bus(1, `UFSA_REG_CTRL, 32'h0, d);
      bus(0, `UFSA_REG_ADDR, 0, v);
      check("global clock advance", v, 6);
      bus(1, `UFSA_REG_ADDR, {23'h0, s}, v);
      bus(1, `UFSA_REG_CTRL, 32'hc, v);
      n = 0;
      do bus(0, `UFSA_REG_LEVEL, 0, v); while (v !== `UFSA_FIFO_DEPTH && ++n < 300);
      bus(1, `UFSA_REG_CTRL, 32'h0, v);
      bus(0, `UFSA_REG_LEVEL, 0, v);
      check("fifo full", v, `UFSA_FIFO_DEPTH);
      for (int i = 0; i < `UFSA_FIFO_DEPTH; i++) begin
         repeat (rnd() % 4) @(posedge ref_clk);
         bus(0, `UFSA_REG_RDATA, 0, v);
         check("stream word", v, mem[(s + i) % 512]);
      end
      bus(0, `UFSA_REG_STATUS, 0, v);
      check("fifo drained", v[1:0], 2'h0);
      bus(1, 8'h40, rnd(), v);
      bus(0, 8'h40, 0, v);
      check("unmapped read", v, 0);
      osc_period();
      end_of_test();
   end
endmodule : ufsa_core_tb
`default_nettype wire

// file: tb/ufsa_user_logic.sv
// Behavioural model of the array logic that drives the flash request and address pins
`default_nettype none
module ufsa_user_logic (
   input wire logic ref_clk,
   input wire logic busy,
   output logic program_req,
   output logic erase_req,
   output logic addr_shift_select,
   output logic addr_shift_clock,
   output logic addr_serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      program_req = 1'b0;
      erase_req = 1'b0;
      addr_shift_select = 1'b0;
      addr_shift_clock = 1'b0;
      addr_serial_in = 1'b0;
   end
   // ****************************************
   // Program or erase request held until busy drops
   // ****************************************
   task automatic flash_op(input bit erase, input int linger, output int cycles);
      int n;
      n = 0;
      cycles = 0;
      @(posedge ref_clk);
      program_req <= !erase;
      erase_req <= erase;
      do @(negedge ref_clk); while (busy !== 1'b1 && ++n < 20);
      while (busy === 1'b1 && cycles < 5000) begin
         @(negedge ref_clk);
         cycles++;
      end
      repeat (linger) @(posedge ref_clk);
      @(posedge ref_clk);
      program_req <= 1'b0;
      erase_req <= 1'b0;
   endtask : flash_op
   // ****************************************
   // Serial address load, most significant bit first
   // ****************************************
   task automatic shift_addr(input logic [8:0] a, input int pace);
      @(posedge ref_clk);
      addr_shift_select <= 1'b1;
      for (int i = 8; i >= 0; i--) begin
         addr_serial_in <= a[i];
         repeat (pace) @(posedge ref_clk);
         addr_shift_clock <= 1'b1;
         repeat (pace) @(posedge ref_clk);
         addr_shift_clock <= 1'b0;
         repeat (pace) @(posedge ref_clk);
      end
      addr_shift_select <= 1'b0;
      addr_serial_in <= ~a[0];
   endtask : shift_addr
   task automatic inc_addr(input int n, input int pace);
      @(posedge ref_clk);
      addr_shift_select <= 1'b0;
      repeat (n) begin
         addr_shift_clock <= 1'b1;
         repeat (pace) @(posedge ref_clk);
         addr_shift_clock <= 1'b0;
         repeat (pace) @(posedge ref_clk);
      end
   endtask : inc_addr
endmodule : ufsa_user_logic
`default_nettype wire
